// [hw/imc_ctrl.sv]
// Dual input gate control, reverse output sequencing and bypass mode selection.
// Assumes host bits arrive as same-clock write strobes with data, and all sense
// pins (comparators, gate pin grounding, tie to bus) are asynchronous levels.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Gate on only if its FET set fitted
// - Sense grounded gate pins at power-on
// - Turn-on needs input ok, flags clear, bus low
// - No FETs: gates and presence read zero
// - First-only fit: second bits stay zero
// - Both fitted: host swaps active input
// - Both fitted: first gate on by default
// - Disable-both forces both gates off
// - Present input chosen, first has priority
// - Dual fit: high-impedance turns both off
// - Reverse-output enable sets disable-both
// - Overvoltage in reverse mode drops gate, host rewrites
// - Watchdog expiry clears reverse-output enable
// - Bypass plus charging turns all switches on
// - Bypass fault clears charge, keeps bypass
module imc_ctrl (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Asynchronous sense pins
   input  wire logic       first_input_sense,
   input  wire logic       first_input_ovp,
   input  wire logic       second_input_sense,
   input  wire logic       second_input_ovp,
   input  wire logic       bus_rail,
   input  wire logic       battery_output_rail,
   input  wire logic       first_gate_pin_grounded,
   input  wire logic       second_gate_pin_grounded,
   input  wire logic       first_input_tied_bus,
   input  wire logic       second_input_tied_bus,
   input  wire logic       bus_overvoltage_fault,
   // Same-clock events
   input  wire logic       watchdog_expired,
   input  wire logic       charge_fault,
   // Host writes
   input  wire logic       disable_both_wr,
   input  wire logic       disable_both_wdata,
   input  wire logic       high_impedance_wr,
   input  wire logic       high_impedance_wdata,
   input  wire logic       first_gate_wr,
   input  wire logic       first_gate_wdata,
   input  wire logic       second_gate_wr,
   input  wire logic       second_gate_wdata,
   input  wire logic       reverse_output_wr,
   input  wire logic       reverse_output_wdata,
   input  wire logic       charge_run_wr,
   input  wire logic       charge_run_wdata,
   input  wire logic       bypass_wr,
   input  wire logic       bypass_wdata,
   input  wire logic       switch_frequency_wr,
   input  wire logic [2:0] switch_frequency_wdata,
   input  wire logic       pulldown_wr,
   input  wire logic [2:0] pulldown_wdata,
   // Pins and status
   output logic            first_input_gate_drive,
   output logic            second_input_gate_drive,
   output logic            first_gate_state,
   output logic            second_gate_state,
   output logic            first_fet_set_present,
   output logic            second_fet_set_present,
   output logic            disable_both_input_gates,
   output logic            high_impedance_select,
   output logic            reverse_output_enable,
   output logic            charge_run,
   output logic            bypass_enable,
   output logic [2:0]      switch_frequency_select,
   output logic            bus_present_flag,
   output logic            output_present_flag,
   output logic            bus_pulldown_on,
   output logic            first_input_pulldown_on,
   output logic            second_input_pulldown_on,
   output logic            blocking_switch,
   output logic            phase1_charge_high_switch,
   output logic            phase1_discharge_high_switch,
   output logic            phase2_charge_high_switch,
   output logic            phase2_discharge_high_switch
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////
   imc_pkg::imc_state_t             s;
   imc_pkg::imc_state_t             next_s;
   logic [imc_pkg::SYNC_W-1:0]      raw;
   logic [imc_pkg::SYNC_W-1:0]      sn;
   logic                            hold1;
   logic                            hold2;
   logic                            start1;
   logic                            start2;

   assign raw = {bus_overvoltage_fault, second_input_tied_bus, first_input_tied_bus,
                 second_gate_pin_grounded, first_gate_pin_grounded, battery_output_rail,
                 bus_rail, second_input_ovp, second_input_sense, first_input_ovp,
                 first_input_sense};

   imc_sync #(
      .W (imc_pkg::SYNC_W)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in (raw),
      .sync_out (sn)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      hold1  = 1'b0;
      hold2  = 1'b0;
      start1 = 1'b0;
      start2 = 1'b0;
      next_s.bus_flag = sn[imc_pkg::S_BUS_PRESENT];
      next_s.out_flag = sn[imc_pkg::S_OUT_PRESENT];
      unique case (s.phase)
         imc_pkg::IMC_DETECT: begin
            // Straps are read only once the synchroniser has settled
            if (s.det_cnt == imc_pkg::DETECT_CYCLES - 4'h1) begin
               next_s.present1 = !sn[imc_pkg::S_GATE1_GND] && !sn[imc_pkg::S_IN1_TIED];
               next_s.present2 = !sn[imc_pkg::S_GATE2_GND] && !sn[imc_pkg::S_IN2_TIED];
               next_s.phase    = imc_pkg::IMC_RUN;
            end else begin
               next_s.det_cnt = s.det_cnt + 4'h1;
            end
         end
         imc_pkg::IMC_RUN: begin
            if (high_impedance_wr) begin
               next_s.hiz = high_impedance_wdata;
            end
            if (disable_both_wr) begin
               next_s.dis_both = disable_both_wdata;
               next_s.auto_hold = 1'b0;
            end
            if (reverse_output_wr) begin
               next_s.otg = reverse_output_wdata;
               if (reverse_output_wdata) begin
                  next_s.dis_both = 1'b1;
               end
            end
            // Hardware clear beats a host set in the same cycle
            if (watchdog_expired) begin
               next_s.otg        = 1'b0;
               next_s.charge_run = 1'b0;
            end
            if (bypass_wr) begin
               next_s.bypass = bypass_wdata;
            end
            if (switch_frequency_wr) begin
               next_s.fsw = switch_frequency_wdata;
            end
            if (pulldown_wr) begin
               {next_s.in2_pd, next_s.in1_pd, next_s.bus_pd} = pulldown_wdata;
            end
            if (charge_run_wr && !watchdog_expired) begin
               next_s.charge_run = charge_run_wdata;
            end
            if (charge_fault) begin
               next_s.charge_run = 1'b0;
            end

            // Conditions that must keep holding while a gate is on
            hold1 = s.present1 && sn[imc_pkg::S_IN1_PRESENT] && !sn[imc_pkg::S_IN1_OVP]
                    && !next_s.dis_both && !next_s.hiz
                    && !(next_s.otg && sn[imc_pkg::S_BUS_OVP]);
            hold2 = s.present2 && sn[imc_pkg::S_IN2_PRESENT] && !sn[imc_pkg::S_IN2_OVP]
                    && !next_s.dis_both && !next_s.hiz
                    && !(next_s.otg && sn[imc_pkg::S_BUS_OVP]);
            // The bus must be low to turn on, else the gate would fight a live rail
            start1 = hold1 && !sn[imc_pkg::S_BUS_PRESENT];
            start2 = hold2 && !sn[imc_pkg::S_BUS_PRESENT];

            if (!hold1) begin
               next_s.gate1 = 1'b0;
            end
            if (!hold2) begin
               next_s.gate2 = 1'b0;
            end
            if (first_gate_wr) begin
               if (first_gate_wdata && start1) begin
                  next_s.gate1     = 1'b1;
                  next_s.gate2     = 1'b0;
                  next_s.auto_hold = 1'b0;
               end else if (!first_gate_wdata) begin
                  next_s.gate1     = 1'b0;
                  next_s.auto_hold = 1'b1;
               end
            end else if (second_gate_wr) begin
               if (second_gate_wdata && start2) begin
                  next_s.gate2     = 1'b1;
                  next_s.gate1     = 1'b0;
                  next_s.auto_hold = 1'b0;
               end else if (!second_gate_wdata) begin
                  next_s.gate2     = 1'b0;
                  next_s.auto_hold = 1'b1;
               end
            end else if (!next_s.otg && !next_s.auto_hold && !next_s.gate1
                         && !next_s.gate2) begin
               // Reverse mode never auto-selects: the host picks the port again
               if (start1) begin
                  next_s.gate1 = 1'b1;
               end else if (start2) begin
                  next_s.gate2 = 1'b1;
               end
            end
         end
      endcase
      next_s.bypass_sw = (s.phase == imc_pkg::IMC_RUN) && next_s.bypass
                         && next_s.charge_run;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s            <= '0;
         s.phase      <= imc_pkg::IMC_DETECT;
         s.dis_both   <= imc_pkg::RST_DIS_BOTH;
         s.hiz        <= imc_pkg::RST_HIZ;
         s.bypass     <= imc_pkg::RST_BYPASS;
         s.fsw        <= imc_pkg::RST_FSW;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign first_input_gate_drive       = s.gate1;
   assign second_input_gate_drive      = s.gate2;
   assign first_gate_state             = s.gate1;
   assign second_gate_state            = s.gate2;
   assign first_fet_set_present        = s.present1;
   assign second_fet_set_present       = s.present2;
   assign disable_both_input_gates     = s.dis_both;
   assign high_impedance_select        = s.hiz;
   assign reverse_output_enable        = s.otg;
   assign charge_run                   = s.charge_run;
   assign bypass_enable                = s.bypass;
   assign switch_frequency_select      = s.fsw;
   assign bus_present_flag             = s.bus_flag;
   assign output_present_flag          = s.out_flag;
   assign bus_pulldown_on              = s.bus_pd;
   assign first_input_pulldown_on      = s.in1_pd;
   assign second_input_pulldown_on     = s.in2_pd;
   assign blocking_switch              = s.bypass_sw;
   assign phase1_charge_high_switch    = s.bypass_sw;
   assign phase1_discharge_high_switch = s.bypass_sw;
   assign phase2_charge_high_switch    = s.bypass_sw;
   assign phase2_discharge_high_switch = s.bypass_sw;

endmodule : imc_ctrl

`default_nettype wire

// [hw/imc_sync.sv]
// Three-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence is given.
`default_nettype none

module imc_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // A change counts only once stages two and three agree, filtering one-cycle glitches
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         for (int i = 0; i < W; i++) begin
            if (stage2[i] == stage3[i]) begin
               sync_out[i] <= stage3[i];
            end
         end
      end
   end

endmodule : imc_sync

`default_nettype wire

// [include/imc_pkg.sv]
// Constants and types shared by the input mux and charge mode control logic.
// Assumes a single 40 MHz core clock; all pin sense inputs arrive asynchronously.
`default_nettype none

package imc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin sense vector layout (bit positions inside the synchronised bundle)
   localparam int SYNC_W        = 11;
   localparam int S_IN1_PRESENT = 0;
   localparam int S_IN1_OVP     = 1;
   localparam int S_IN2_PRESENT = 2;
   localparam int S_IN2_OVP     = 3;
   localparam int S_BUS_PRESENT = 4;
   localparam int S_OUT_PRESENT = 5;
   localparam int S_GATE1_GND   = 6;
   localparam int S_GATE2_GND   = 7;
   localparam int S_IN1_TIED    = 8;
   localparam int S_IN2_TIED    = 9;
   localparam int S_BUS_OVP     = 10;

   ////////////////////////////////////////////////////////////////////////////////
   // Power-on detection timing; covers synchroniser latency before sampling straps
   localparam logic [3:0] DETECT_CYCLES = 4'h8;

   // Values after reset
   localparam logic       RST_DIS_BOTH = 1'h0;
   localparam logic       RST_HIZ      = 1'h0;
   localparam logic       RST_BYPASS   = 1'h0;
   localparam logic [2:0] RST_FSW      = 3'h0;

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      IMC_DETECT = 2'h1,
      IMC_RUN    = 2'h2
   } imc_phase_t;

   typedef struct packed {
      imc_phase_t phase;
      logic [3:0] det_cnt;
      logic       present1;
      logic       present2;
      logic       gate1;
      logic       gate2;
      logic       auto_hold;
      logic       dis_both;
      logic       hiz;
      logic       otg;
      logic       charge_run;
      logic       bypass;
      logic [2:0] fsw;
      logic       bus_pd;
      logic       in1_pd;
      logic       in2_pd;
      logic       bypass_sw;
      logic       bus_flag;
      logic       out_flag;
   } imc_state_t;

endpackage : imc_pkg

`default_nettype wire

// [tb/imc_ctrl_bench.sv]
// Self-checking bench for the input mux and charge mode control block.
// Assumes the switch set model drives the strap and sense pins.
`default_nettype none

module imc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [10:0] stb = 11'h000;
   logic [2:0]  wd = 3'h0;
   logic        fit1 = 1'b0, fit2 = 1'b0, src1 = 1'b0, src2 = 1'b0, bus_rail = 1'b0;
   logic        first_input_ovp = 1'b0, second_input_ovp = 1'b0, bus_overvoltage_fault = 1'b0;
   logic        battery_output_rail = 1'b0;
   int          err_total = 0, cmp_count = 0;
   wire logic   first_input_sense, second_input_sense, first_input_tied_bus;
   wire logic   second_input_tied_bus, first_gate_pin_grounded, second_gate_pin_grounded;
   wire logic   watchdog_expired, charge_fault, disable_both_wr, high_impedance_wr;
   wire logic   first_gate_wr, second_gate_wr, reverse_output_wr, charge_run_wr, bypass_wr;
   wire logic   switch_frequency_wr, pulldown_wr, disable_both_wdata, high_impedance_wdata;
   wire logic   first_gate_wdata, second_gate_wdata, reverse_output_wdata, charge_run_wdata;
   wire logic   bypass_wdata, first_input_gate_drive, second_input_gate_drive;
   wire logic   first_gate_state, second_gate_state, first_fet_set_present;
   wire logic   second_fet_set_present, disable_both_input_gates, high_impedance_select;
   wire logic   reverse_output_enable, charge_run, bypass_enable, bus_present_flag;
   wire logic   output_present_flag, bus_pulldown_on, first_input_pulldown_on;
   wire logic   second_input_pulldown_on, blocking_switch, phase1_charge_high_switch;
   wire logic   phase1_discharge_high_switch, phase2_charge_high_switch;
   wire logic   phase2_discharge_high_switch;
   wire logic [2:0] switch_frequency_select, switch_frequency_wdata = wd, pulldown_wdata = wd;
   wire logic [7:0] st = {first_input_gate_drive, second_input_gate_drive, first_gate_state,
      second_gate_state, first_fet_set_present, second_fet_set_present,
      disable_both_input_gates, high_impedance_select};
   wire logic [7:0] md = {reverse_output_enable, charge_run, bypass_enable, blocking_switch,
      bus_present_flag, output_present_flag, bus_pulldown_on, first_input_pulldown_on};

   assign {charge_fault, watchdog_expired, pulldown_wr, switch_frequency_wr, bypass_wr,
      charge_run_wr, reverse_output_wr, second_gate_wr, first_gate_wr, high_impedance_wr,
      disable_both_wr} = stb;
   assign {bypass_wdata, charge_run_wdata, reverse_output_wdata, second_gate_wdata,
      first_gate_wdata, high_impedance_wdata, disable_both_wdata} = {7{wd[0]}};

   imc_ctrl i_imc_ctrl (.*);
   imc_fet_model i_imc_fet_model (.*);

   always #12.5 core_clk = ~core_clk;

   ////////////////////////////////////////
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One-cycle strobe, then one idle cycle so the answer has landed
   task automatic put(input int i, input logic [2:0] d);
      stb[i] = 1'b1;
      wd = d;
      @(negedge core_clk);
      stb[i] = 1'b0;
      @(negedge core_clk);
   endtask : put

   task automatic op(input int i, input logic [2:0] d, input logic [7:0] e, input bit m);
      put(i, d);
      chk(m ? md : st, e);
   endtask : op

   // Sense pins need synchroniser plus register time before they show
   task automatic ws(input logic [7:0] e, input bit m);
      repeat (8) @(negedge core_clk);
      chk(m ? md : st, e);
   endtask : ws

   task automatic start(input logic f1, input logic f2);
      rst_n = 1'b0;
      fit1 = f1;
      fit2 = f2;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (12) @(negedge core_clk);
   endtask : start

   initial begin
      #50us;
      err_total++;
      report_and_stop();
   end

   initial begin
      bus_rail = 1'b1;
      src1 = 1'b1;
      start(1'b0, 1'b0);
      ws(8'h00, 1'b0);
      ws(8'h08, 1'b1);
      op(1, 3'h1, 8'h01, 1'b0);
      op(1, 3'h0, 8'h00, 1'b0);
      $display("Test 1 done at %0t", $time);
      bus_rail = 1'b0;
      start(1'b1, 1'b0);
      ws(8'ha8, 1'b0);
      op(0, 3'h1, 8'h0a, 1'b0);
      put(0, 3'h0);
      ws(8'ha8, 1'b0);
      op(1, 3'h1, 8'h09, 1'b0);
      put(1, 3'h0);
      ws(8'ha8, 1'b0);
      first_input_ovp = 1'b1;
      ws(8'h08, 1'b0);
      first_input_ovp = 1'b0;
      ws(8'ha8, 1'b0);
      $display("Test 2 done at %0t", $time);
      src2 = 1'b1;
      start(1'b1, 1'b1);
      ws(8'hac, 1'b0);
      op(2, 3'h0, 8'h0c, 1'b0);
      op(3, 3'h1, 8'h5c, 1'b0);
      op(1, 3'h1, 8'h0d, 1'b0);
      put(1, 3'h0);
      ws(8'hac, 1'b0);
      op(0, 3'h1, 8'h0e, 1'b0);
      src1 = 1'b0;
      ws(8'h0e, 1'b0);
      put(0, 3'h0);
      ws(8'h5c, 1'b0);
      second_input_ovp = 1'b1;
      ws(8'h0c, 1'b0);
      second_input_ovp = 1'b0;
      ws(8'h5c, 1'b0);
      $display("Test 3 done at %0t", $time);
      src1 = 1'b1;
      op(4, 3'h1, 8'h0e, 1'b0);
      chk(md, 8'h80);
      op(0, 3'h0, 8'h0c, 1'b0);
      op(2, 3'h1, 8'hac, 1'b0);
      bus_overvoltage_fault = 1'b1;
      ws(8'h0c, 1'b0);
      chk(md, 8'h80);
      bus_overvoltage_fault = 1'b0;
      ws(8'h0c, 1'b0);
      op(2, 3'h1, 8'hac, 1'b0);
      op(8, 3'h7, 8'h83, 1'b1);
      chk({7'h00, second_input_pulldown_on}, 8'h01);
      op(2, 3'h0, 8'h0c, 1'b0);
      op(4, 3'h0, 8'h03, 1'b1);
      put(4, 3'h1);
      op(9, 3'h1, 8'h03, 1'b1);
      $display("Test 4 done at %0t", $time);
      bus_rail = 1'b1;
      battery_output_rail = 1'b1;
      ws(8'h0f, 1'b1);
      op(8, 3'h0, 8'h0c, 1'b1);
      chk({7'h00, second_input_pulldown_on}, 8'h00);
      put(7, 3'h5);
      chk({5'h00, switch_frequency_select}, 8'h05);
      op(6, 3'h1, 8'h2c, 1'b1);
      op(5, 3'h1, 8'h7c, 1'b1);
      op(10, 3'h1, 8'h2c, 1'b1);
      op(6, 3'h0, 8'h0c, 1'b1);
      op(5, 3'h1, 8'h4c, 1'b1);
      op(9, 3'h1, 8'h0c, 1'b1);
      $display("Test 5 done at %0t", $time);
      report_and_stop();
   end
endmodule : imc_ctrl_bench

`default_nettype wire

// [tb/imc_ctrl_props.sv]
// Port checker for the input mux and charge mode control block.
// Assumes one clock domain; it watches the top module's ports only.
`default_nettype none

module imc_ctrl_props (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic first_input_ovp,
   input wire logic watchdog_expired,
   input wire logic charge_fault,
   input wire logic reverse_output_wr,
   input wire logic reverse_output_wdata,
   input wire logic bypass_wr,
   input wire logic first_input_gate_drive,
   input wire logic second_input_gate_drive,
   input wire logic first_fet_set_present,
   input wire logic second_fet_set_present,
   input wire logic disable_both_input_gates,
   input wire logic high_impedance_select,
   input wire logic reverse_output_enable,
   input wire logic charge_run,
   input wire logic bypass_enable,
   input wire logic blocking_switch,
   input wire logic phase1_charge_high_switch,
   input wire logic phase1_discharge_high_switch,
   input wire logic phase2_charge_high_switch,
   input wire logic phase2_discharge_high_switch
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] age;
   logic       run;

   ////////////////////////////////////////
   // Writes during presence detection are dropped, so only judge later ones
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         age <= 4'h0;
      else if (age != 4'hf)
         age <= age + 4'h1;
   end
   assign run = age > 4'h9;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_otg_req;
      run && reverse_output_wr && reverse_output_wdata && !watchdog_expired;
   endsequence
   sequence s_otg_on;
      reverse_output_enable && disable_both_input_gates && !first_input_gate_drive;
   endsequence
   sequence s_ovp_held;
      first_input_ovp[*6];
   endsequence

   property p_otg;
      s_otg_req |=> s_otg_on;
   endproperty
   property p_ovp;
      s_ovp_held |-> !first_input_gate_drive;
   endproperty
   property p_fit1;
      first_input_gate_drive |-> first_fet_set_present;
   endproperty
   property p_fit2;
      second_input_gate_drive |-> second_fet_set_present;
   endproperty
   property p_dis;
      disable_both_input_gates |-> !first_input_gate_drive && !second_input_gate_drive;
   endproperty
   property p_hiz;
      high_impedance_select |-> !first_input_gate_drive && !second_input_gate_drive;
   endproperty
   property p_rise;
      $rose(first_input_gate_drive) |-> !disable_both_input_gates && !high_impedance_select;
   endproperty
   property p_wd;
      watchdog_expired |=> !reverse_output_enable && !charge_run;
   endproperty
   property p_fault;
      charge_fault && !bypass_wr |=> !charge_run && !blocking_switch
         && bypass_enable == $past(bypass_enable);
   endproperty
   property p_byp;
      blocking_switch == (bypass_enable && charge_run)
         && phase1_charge_high_switch == blocking_switch
         && phase1_discharge_high_switch == blocking_switch
         && phase2_charge_high_switch == blocking_switch
         && phase2_discharge_high_switch == blocking_switch;
   endproperty

   a_otg: assert property (p_otg)
      else $error("reverse entry left gates enabled");
   a_ovp: assert property (p_ovp)
      else $error("gate kept on through overvoltage");
   a_fit1: assert property (p_fit1)
      else $error("first gate on without its switch set");
   a_fit2: assert property (p_fit2)
      else $error("second gate on without its switch set");
   a_dis: assert property (p_dis)
      else $error("gate on while both are disabled");
   a_hiz: assert property (p_hiz)
      else $error("gate on in high impedance");
   a_rise: assert property (p_rise)
      else $error("gate turned on while blocked");
   a_wd: assert property (p_wd)
      else $error("watchdog left reverse or charge on");
   a_fault: assert property (p_fault)
      else $error("fault handling of charge or bypass wrong");
   a_byp: assert property (p_byp)
      else $error("bypass switches disagree with mode");

endmodule : imc_ctrl_props

bind imc_ctrl imc_ctrl_props i_imc_ctrl_props (.*);

`default_nettype wire

// [tb/imc_fet_model.sv]
// External input switch sets and strap wiring around the control block.
// Assumes the bench chooses the fitted sets before reset is released.
`default_nettype none

module imc_fet_model (
   input  wire logic fit1,
   input  wire logic fit2,
   input  wire logic src1,
   input  wire logic src2,
   input  wire logic bus_rail,
   output logic      first_input_sense,
   output logic      second_input_sense,
   output logic      first_gate_pin_grounded,
   output logic      second_gate_pin_grounded,
   output logic      first_input_tied_bus,
   output logic      second_input_tied_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   // An unfitted set has its sense pin on the bus and its gate pin grounded
   assign first_input_sense        = fit1 ? src1 : bus_rail;
   assign second_input_sense       = fit2 ? src2 : bus_rail;
   assign first_gate_pin_grounded  = !fit1;
   assign second_gate_pin_grounded = !fit2;
   assign first_input_tied_bus     = !fit1;
   assign second_input_tied_bus    = !fit2;
endmodule : imc_fet_model

`default_nettype wire
